// ==== pkg/rt_irq_pkg.sv ====
package rt_irq_pkg;
    // register word and address widths
    localparam int REG_W = 16;
    localparam int ADDR_W = 8;
    typedef logic [REG_W-1:0] reg_word_t;
    typedef logic [ADDR_W-1:0] reg_addr_t;
    // register offsets as printed on the register port
    localparam reg_addr_t RT_IRQ_PENDING_OFS = 8'h09;
    localparam reg_addr_t RT_IRQ_ENABLE_OFS = 8'h12;
    localparam reg_addr_t RT_IRQ_OUTPUT_ENABLE_OFS = 8'h16;
    // shared field positions, same in all three registers; bit 9 only in the log word
    localparam int WAS_BUSY_BIT = 9;
    localparam int RESET_CMD_BIT = 8;
    localparam int INDEX_ZERO_BIT = 7;
    localparam int ILLEGAL_CMD_BIT = 6;
    localparam int BROADCAST_BIT = 5;
    localparam int MSG_ERROR_BIT = 4;
    localparam int ACCESSED_BIT = 3;
    // bits 8..3 hold state; 15..10, 9 and 2..0 read zero
    localparam reg_word_t EVENT_MASK = 16'h01F8;
    // reset values
    localparam reg_word_t RT_IRQ_PENDING_RST = 16'h0000;
    localparam reg_word_t RT_IRQ_ENABLE_RST = 16'h0000;
    localparam reg_word_t RT_IRQ_OUTPUT_ENABLE_RST = 16'h0000;
endpackage

// ==== verilog/rt_event_qualify.sv ====
`timescale 1ns/1ns
module rt_event_qualify
    import rt_irq_pkg::*;
(
    // raw event vector and register state
    input wire rt_irq_pkg::reg_word_t raw_bits,
    input wire rt_irq_pkg::reg_word_t enable_bits,
    input wire rt_irq_pkg::reg_word_t oe_bits,
    // suppression terms
    input wire logic suppress_cfg,
    input wire logic msg_illegal,
    input wire logic msg_busy,
    // qualified results
    output logic [REG_W-1:0] qualified,
    output logic irq_wanted
);
    // suppression covers illegal commands and busy responses
    logic suppress;
    always_comb begin
        // enable gating: disabled bits are dropped here
        qualified = raw_bits & enable_bits & EVENT_MASK;
        // suppress irq pin when suppress_cfg is set and the message is illegal or busy
        suppress = suppress_cfg && (msg_illegal || msg_busy);
        // only output-enabled bits may drive irq
        irq_wanted = ((qualified & oe_bits) != '0) && !suppress;
    end
endmodule

// ==== verilog/rt_log_word.sv ====
`timescale 1ns/1ns
module rt_log_word
    import rt_irq_pkg::*;
(
    // pending value after this event
    input wire rt_irq_pkg::reg_word_t pending_next,
    // busy logging terms
    input wire logic busy_log_cfg,
    input wire logic msg_busy,
    // identification word
    output logic [REG_W-1:0] word
);
    // bit 9 is never set in pending, so it is free for busy status
    always_comb begin
        word = pending_next & EVENT_MASK;
        // busy flag only when logging enabled
        word[WAS_BUSY_BIT] = busy_log_cfg && msg_busy;
    end
endmodule

// ==== verilog/rt_interrupt_control.sv ====
`timescale 1ns/1ns
module rt_interrupt_control
    import rt_irq_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // register port from the host interface layer
    input wire rt_irq_pkg::reg_addr_t reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire rt_irq_pkg::reg_word_t reg_wdata,
    output rt_irq_pkg::reg_word_t reg_rdata,
    // message completion events from the command decoder
    input wire logic evt_valid,
    input wire rt_irq_pkg::reg_word_t evt_bits,
    input wire logic evt_broadcast,
    input wire logic msg_illegal,
    input wire logic msg_busy,
    // configuration bits held elsewhere
    input wire logic irq_suppress_on_error_busy,
    input wire logic log_busy_state_enable,
    input wire logic auto_reset_cfg,
    // other interrupt sources sharing the irq pin
    input wire logic hw_irq_req,
    input wire logic bc_irq_req,
    input wire logic mt_irq_req,
    // outputs
    output logic irq_n,
    output logic rt_summary_pending_flag,
    output logic log_wr,
    output rt_irq_pkg::reg_word_t interrupt_identification_word,
    output logic terminal_reset_needed_n,
    output logic auto_reset_req
);

    ////////////////////////////////////////////////////////////////
    // state
    ////////////////////////////////////////////////////////////////

    reg_word_t enable_ff; // event enable bits
    reg_word_t oe_ff; // irq output enable bits
    reg_word_t pending_ff; // captured enabled events
    reg_word_t nxt_pending; // pending after set and clear
    reg_word_t qualified; // enabled events this cycle
    reg_word_t log_word; // identification word candidate
    reg_word_t rdata_ff; // registered read data
    logic irq_wanted; // event wants the irq pin
    logic irq_hold_ff; // rt part of irq, held until serviced
    logic reset_pin_ff; // reset request pin, active high inside
    logic auto_reset_ff; // automatic reset request
    logic log_wr_ff; // log write strobe
    reg_word_t iiw_ff; // logged identification word
    logic summary_ff; // summary flag set strobe
    logic rd_pending; // host reads pending this cycle
    logic new_event; // at least one enabled event
    logic reset_cmd; // reset terminal command completed
    logic index_zero_evt; // index reached zero event this cycle
    logic illegal_evt; // illegal command event this cycle

    ////////////////////////////////////////////////////////////////
    // event qualification and log word
    ////////////////////////////////////////////////////////////////

    // enable sampled at the event itself, so old events are never replayed
    rt_event_qualify u_qualify (
        .raw_bits(evt_valid ? evt_bits : '0),
        .enable_bits(enable_ff),
        .oe_bits(oe_ff),
        .suppress_cfg(irq_suppress_on_error_busy),
        .msg_illegal(msg_illegal),
        .msg_busy(msg_busy),
        .qualified(qualified),
        .irq_wanted(irq_wanted)
    );

    rt_log_word u_log_word (
        .pending_next(nxt_pending),
        .busy_log_cfg(log_busy_state_enable),
        .msg_busy(msg_busy),
        .word(log_word)
    );

    // decoded strobes
    always_comb begin
        rd_pending = reg_rd && (reg_addr == RT_IRQ_PENDING_OFS);
        new_event = (qualified != '0);
        // reset command arrives on bit 8
        reset_cmd = evt_valid && evt_bits[RESET_CMD_BIT];
        // index reached zero arrives on bit 7
        index_zero_evt = evt_valid && evt_bits[INDEX_ZERO_BIT];
        // illegal command arrives on bit 6
        illegal_evt = evt_valid && evt_bits[ILLEGAL_CMD_BIT];
    end

    ////////////////////////////////////////////////////////////////
    // register writes
    ////////////////////////////////////////////////////////////////

    // enable register; only bits 8..3 can be written
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_ff <= RT_IRQ_ENABLE_RST;
        end else if (reg_wr && reg_addr == RT_IRQ_ENABLE_OFS) begin
            enable_ff <= reg_wdata & EVENT_MASK;
        end
    end

    // output enable register, same layout as enable
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            oe_ff <= RT_IRQ_OUTPUT_ENABLE_RST;
        end else if (reg_wr && reg_addr == RT_IRQ_OUTPUT_ENABLE_OFS) begin
            oe_ff <= reg_wdata & EVENT_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////
    // pending register
    ////////////////////////////////////////////////////////////////

    // read clear and new events in the same cycle: the event survives
    always_comb begin
        nxt_pending = rd_pending ? RT_IRQ_PENDING_RST : pending_ff;
        // new bits are ORed in, set wins
        nxt_pending = nxt_pending | qualified;
    end

    // pending is read-clear only; host writes are ignored
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pending_ff <= RT_IRQ_PENDING_RST;
        end else begin
            pending_ff <= nxt_pending;
        end
    end

    ////////////////////////////////////////////////////////////////
    // read data
    ////////////////////////////////////////////////////////////////

    // data shows one cycle after the read strobe
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= '0;
        end else if (reg_rd) begin
            if (reg_addr == RT_IRQ_PENDING_OFS) begin
                rdata_ff <= pending_ff;
            end else if (reg_addr == RT_IRQ_ENABLE_OFS) begin
                rdata_ff <= enable_ff;
            end else if (reg_addr == RT_IRQ_OUTPUT_ENABLE_OFS) begin
                rdata_ff <= oe_ff;
            end else begin
                // other addresses belong to other blocks
                rdata_ff <= '0;
            end
        end
    end
    assign reg_rdata = rdata_ff;

    ////////////////////////////////////////////////////////////////
    // log buffer strobe and summary flag
    ////////////////////////////////////////////////////////////////

    // one log entry per message that sets any pending bit
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            log_wr_ff <= 1'b0;
            iiw_ff <= '0;
        end else begin
            log_wr_ff <= new_event;
            if (new_event) begin
                // word taken from the updated pending value
                iiw_ff <= log_word;
            end
        end
    end
    assign log_wr = log_wr_ff;
    assign interrupt_identification_word = iiw_ff;

    // summary flag is a set strobe; the hardware pending register ORs it in
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            summary_ff <= 1'b0;
        end else begin
            // summary flag on any new pending bit
            summary_ff <= new_event;
        end
    end
    assign rt_summary_pending_flag = summary_ff;

    ////////////////////////////////////////////////////////////////
    // interrupt request
    ////////////////////////////////////////////////////////////////

    // held until the host reads pending; a new output-enabled, unsuppressed event (irq_wanted) in that cycle wins
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_hold_ff <= 1'b0;
        end else if (irq_wanted) begin
            irq_hold_ff <= 1'b1;
        end else if (rd_pending) begin
            irq_hold_ff <= 1'b0;
        end
    end

    assign irq_n = !(irq_hold_ff || hw_irq_req || bc_irq_req || mt_irq_req);

    ////////////////////////////////////////////////////////////////
    // reset terminal command outputs
    ////////////////////////////////////////////////////////////////

    // pin pulses one cycle; pending and irq are left alone when disabled
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_pin_ff <= 1'b0;
            auto_reset_ff <= 1'b0;
        end else begin
            reset_pin_ff <= reset_cmd && (!enable_ff[RESET_CMD_BIT] || evt_broadcast);
            auto_reset_ff <= reset_cmd && !enable_ff[RESET_CMD_BIT] && auto_reset_cfg;
        end
    end
    assign terminal_reset_needed_n = !reset_pin_ff;
    assign auto_reset_req = auto_reset_ff;

    ////////////////////////////////////////////////////////////////
    // assertions
    ////////////////////////////////////////////////////////////////

    // an enabled event completing a message
    sequence seq_enabled_event;
        evt_valid && ((evt_bits & enable_ff & EVENT_MASK) != '0);
    endsequence

    // an enabled event that should raise the pin
    sequence seq_high_event;
        seq_enabled_event ##0 ((evt_bits & enable_ff & oe_ff) != '0)
            ##0 !(irq_suppress_on_error_busy && (msg_illegal || msg_busy));
    endsequence

    a_disabled_ignored: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        evt_valid |=> ((pending_ff & ~$past(pending_ff)) & ~$past(enable_ff)) == '0)
        else $error("disabled event reached pending");

    a_pending_or: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !rd_pending |=> (pending_ff & $past(pending_ff)) == $past(pending_ff))
        else $error("pending bit lost without read");

    a_event_logged: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        seq_enabled_event |=> log_wr && rt_summary_pending_flag
            && ((pending_ff & $past(evt_bits & enable_ff & EVENT_MASK)) != '0))
        else $error("enabled event not logged");

    a_summary_flag: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        rt_summary_pending_flag |-> $past(evt_valid) && log_wr)
        else $error("summary flag without event");

    a_irq_raised: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        seq_high_event |=> !irq_n [*2] or (!irq_n ##1 $past(rd_pending)))
        else $error("irq not asserted at completion");

    a_low_priority: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        evt_valid && !irq_hold_ff && ((evt_bits & enable_ff & oe_ff) == '0)
            |=> !irq_hold_ff)
        else $error("low priority event raised irq");

    a_suppressed: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        evt_valid && !irq_hold_ff && irq_suppress_on_error_busy && (msg_illegal || msg_busy)
            |=> !irq_hold_ff)
        else $error("irq not suppressed");

    a_iiw_mirror: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        log_wr |-> (interrupt_identification_word & EVENT_MASK) == pending_ff)
        else $error("log word differs from pending");

    a_was_busy: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        log_wr |-> interrupt_identification_word[WAS_BUSY_BIT]
            == $past(log_busy_state_enable && msg_busy))
        else $error("busy flag wrong in log word");

    a_reserved_zero: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        reg_rd |=> (reg_rdata & ~EVENT_MASK) == '0)
        else $error("reserved bits read nonzero");

    a_read_clears: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        rd_pending && !evt_valid |=> pending_ff == '0 && reg_rdata == $past(pending_ff))
        else $error("pending read did not clear");

    a_reset_pin: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        reset_cmd && (!enable_ff[RESET_CMD_BIT] || evt_broadcast)
            |=> !terminal_reset_needed_n ##1 (terminal_reset_needed_n || $past(reset_cmd)))
        else $error("reset pin not pulsed");

    // a disabled reset command must not leave a trace in pending
    a_reset_quiet: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        reset_cmd && !enable_ff[RESET_CMD_BIT] && !rd_pending
            |=> pending_ff[RESET_CMD_BIT] == $past(pending_ff[RESET_CMD_BIT]))
        else $error("disabled reset command reached pending");

    a_auto_reset: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        reset_cmd && !enable_ff[RESET_CMD_BIT] && auto_reset_cfg |=> auto_reset_req)
        else $error("automatic reset not requested");

    a_index_zero: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        index_zero_evt && enable_ff[INDEX_ZERO_BIT]
            |=> pending_ff[INDEX_ZERO_BIT] && log_wr)
        else $error("index zero event not captured");

    a_illegal_cmd: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        illegal_evt && enable_ff[ILLEGAL_CMD_BIT]
            |=> pending_ff[ILLEGAL_CMD_BIT] && interrupt_identification_word[ILLEGAL_CMD_BIT])
        else $error("illegal command event not captured");

    a_irq_cleared: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        rd_pending && !irq_wanted |=> !irq_hold_ff)
        else $error("irq hold not cleared by pending read");

endmodule

// ==== verification/rt_host_model.sv ====
`timescale 1ns/1ns
module rt_host_model
    import rt_irq_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // register port towards the device
    output rt_irq_pkg::reg_addr_t reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output rt_irq_pkg::reg_word_t reg_wdata,
    input wire rt_irq_pkg::reg_word_t reg_rdata
);
    ////////////////////////////////////////////////////////////////////////
    // idle port at time zero
    initial begin
        reg_addr = 8'hFF;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
    end

    // one-cycle write strobe; data inverted after release so stale values never pass
    task automatic write_reg(input reg_addr_t a, input reg_word_t d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask

    // read data is registered, so it is taken just after the strobe edge
    task automatic read_reg(input reg_addr_t a, output reg_word_t d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask
endmodule

// ==== verification/rt_interrupt_control_tb.sv ====
`timescale 1ns/1ns
module rt_interrupt_control_tb;
    import rt_irq_pkg::*;
    logic ref_clk, rst_n, reg_wr, reg_rd, evt_valid, evt_broadcast, msg_illegal, msg_busy;
    logic irq_suppress_on_error_busy, log_busy_state_enable, auto_reset_cfg;
    logic hw_irq_req, bc_irq_req, mt_irq_req, irq_n, rt_summary_pending_flag, log_wr;
    logic terminal_reset_needed_n, auto_reset_req;
    reg_addr_t reg_addr;
    reg_word_t reg_wdata, reg_rdata, evt_bits, interrupt_identification_word;
    // expected register state kept by the bench
    reg_word_t exp_en, exp_oe, exp_pend, w;
    logic exp_hold;
    int n_errors, n_tests, seed;
    logic [31:0] r;

    rt_interrupt_control i_rt_interrupt_control (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .evt_valid(evt_valid),
        .evt_bits(evt_bits), .evt_broadcast(evt_broadcast), .msg_illegal(msg_illegal), .msg_busy(msg_busy),
        .irq_suppress_on_error_busy(irq_suppress_on_error_busy), .log_busy_state_enable(log_busy_state_enable),
        .auto_reset_cfg(auto_reset_cfg), .hw_irq_req(hw_irq_req), .bc_irq_req(bc_irq_req), .mt_irq_req(mt_irq_req),
        .irq_n(irq_n), .rt_summary_pending_flag(rt_summary_pending_flag), .log_wr(log_wr),
        .interrupt_identification_word(interrupt_identification_word),
        .terminal_reset_needed_n(terminal_reset_needed_n), .auto_reset_req(auto_reset_req));
    rt_host_model i_rt_host_model (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input reg_word_t got, input reg_word_t exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // irq pin is the shared low-active OR of all sources
    function automatic logic irq_exp();
        return !(exp_hold || hw_irq_req || bc_irq_req || mt_irq_req);
    endfunction

    task automatic set_regs(input reg_word_t en, input reg_word_t oe);
        i_rt_host_model.write_reg(RT_IRQ_ENABLE_OFS, en);
        i_rt_host_model.write_reg(RT_IRQ_OUTPUT_ENABLE_OFS, oe);
        exp_en = en & EVENT_MASK;
        exp_oe = oe & EVENT_MASK;
    endtask

    // read pending: returns the accumulated value, then clears it and the irq hold
    task automatic read_pend();
        reg_word_t d;
        i_rt_host_model.read_reg(RT_IRQ_PENDING_OFS, d);
        check(d, exp_pend);
        exp_pend = 16'h0000;
        exp_hold = 1'b0;
        check({15'h0, irq_n}, {15'h0, irq_exp()});
    endtask

    // one message completion, outputs checked in the cycle after
    task automatic fire(input reg_word_t bits, input logic bc, input logic ill, input logic busy);
        reg_word_t q;
        logic irq_w;
        logic rst_req;
        @(posedge ref_clk);
        q = bits & exp_en & EVENT_MASK;
        irq_w = (|(q & exp_oe)) && !(irq_suppress_on_error_busy && (ill || busy));
        rst_req = bits[RESET_CMD_BIT] && (!exp_en[RESET_CMD_BIT] || bc);
        evt_valid <= 1'b1;
        evt_bits <= bits;
        evt_broadcast <= bc;
        msg_illegal <= ill;
        msg_busy <= busy;
        @(posedge ref_clk);
        evt_valid <= 1'b0;
        evt_bits <= ~bits;
        #1;
        exp_pend = exp_pend | q;
        exp_hold = exp_hold | irq_w;
        check({15'h0, log_wr}, {15'h0, |q});
        check({15'h0, rt_summary_pending_flag}, {15'h0, |q});
        if (|q) begin
            check(interrupt_identification_word, exp_pend | {6'h0, log_busy_state_enable & busy, 9'h0});
        end
        check({15'h0, irq_n}, {15'h0, irq_exp()});
        check({15'h0, terminal_reset_needed_n}, {15'h0, !rst_req});
        check({15'h0, auto_reset_req}, {15'h0, bits[RESET_CMD_BIT] & !exp_en[RESET_CMD_BIT] & auto_reset_cfg});
        @(posedge ref_clk);
        #1;
        check({15'h0, log_wr | rt_summary_pending_flag}, 16'h0000);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // watchdog, far beyond the expected run of about 1200 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        print_verdict();
    end

    initial begin
        {rst_n, evt_valid, evt_broadcast, msg_illegal, msg_busy} = '0;
        {irq_suppress_on_error_busy, log_busy_state_enable, auto_reset_cfg} = '0;
        {hw_irq_req, bc_irq_req, mt_irq_req} = '0;
        evt_bits = 16'h0000;
        {exp_en, exp_oe, exp_pend, exp_hold} = '0;
        seed = 32'h9FF9705F;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        // reset values and reserved bits of all three registers
        for (int k = 0; k < 4; k++) begin
            reg_addr_t a;
            a = (k == 0) ? RT_IRQ_PENDING_OFS : (k == 1) ? RT_IRQ_ENABLE_OFS : (k == 2) ? RT_IRQ_OUTPUT_ENABLE_OFS : 8'h55;
            i_rt_host_model.read_reg(a, w);
            check(w, 16'h0000);
            i_rt_host_model.write_reg(a, 16'hFFFF);
            i_rt_host_model.read_reg(a, w);
            check(w, (k == 1 || k == 2) ? EVENT_MASK : 16'h0000);
        end
        set_regs(16'h0000, 16'h0000);
        $display("test registers done");
        // disabled event then late enable; then high, low priority and suppressed irq
        fire(16'h0040, 1'b0, 1'b1, 1'b0);
        set_regs(16'h01F8, 16'h0040);
        read_pend();
        fire(16'h0040, 1'b0, 1'b1, 1'b0);
        fire(16'h0080, 1'b0, 1'b0, 1'b0);
        read_pend();
        fire(16'h0008, 1'b0, 1'b0, 1'b1);
        @(posedge ref_clk);
        irq_suppress_on_error_busy <= 1'b1;
        fire(16'h0040, 1'b0, 1'b1, 1'b0);
        read_pend();
        // reset command: disabled, broadcast while enabled, and enabled
        @(posedge ref_clk);
        auto_reset_cfg <= 1'b1;
        set_regs(16'h00F8, 16'h01F8);
        fire(16'h0100, 1'b0, 1'b0, 1'b0);
        set_regs(16'h01F8, 16'h01F8);
        fire(16'h0100, 1'b1, 1'b0, 1'b0);
        fire(16'h0100, 1'b0, 1'b0, 1'b0);
        read_pend();
        $display("test directed done");
        // random traffic with random configuration and other sources
        for (int i = 0; i < 200; i++) begin
            r = $random(seed);
            @(posedge ref_clk);
            irq_suppress_on_error_busy <= r[0];
            log_busy_state_enable <= r[1];
            auto_reset_cfg <= r[2];
            hw_irq_req <= (r[5:3] == 3'h0);
            bc_irq_req <= (r[8:6] == 3'h0);
            mt_irq_req <= (r[11:9] == 3'h0);
            if (r[13:12] == 2'h0) begin
                set_regs(16'($random(seed)), 16'($random(seed)));
            end
            fire(16'($random(seed)) & EVENT_MASK, r[16], r[17], r[18]);
            if (r[20:19] == 2'h0) begin
                read_pend();
            end
        end
        read_pend();
        $display("test random done");
        print_verdict();
    end
endmodule
